// *** tsm_defines.svh ***
`ifndef TSM_DEFINES_SVH
`define TSM_DEFINES_SVH

// register byte offsets
`define TSM_OFF_CTRL    8'h00
`define TSM_OFF_MODE    8'h08
`define TSM_OFF_ENA     8'h0C
`define TSM_OFF_SR      8'h10

// reset values
`define TSM_RST_RUN     1'b0
`define TSM_RST_MODE    3'h0
`define TSM_RST_ENA     15'h0000
`define TSM_RST_SR      8'h00

// field positions
`define TSM_RUN_BIT     0
`define TSM_MODE_LSB    0
`define TSM_SRC_LSB     4
`define TSM_DE_LSB      8
`define TSM_ENA_W       15
`define TSM_SR_W        8

// bus answers
`define TSM_RESP_OKAY   2'h0
`define TSM_RESP_SLVERR 2'h2

// timing: synchroniser depth on pin inputs
`define TSM_SYNC_STAGES 2

`endif

// *** tsm_pkg.sv ***
package tsm_pkg;

    typedef enum logic [2:0] {
        TSM_SM_DIS   = 3'b000,
        TSM_SM_QD0   = 3'b001,
        TSM_SM_QD1   = 3'b010,
        TSM_SM_QD2   = 3'b011,
        TSM_SM_RST   = 3'b100,
        TSM_SM_PAUSE = 3'b101,
        TSM_SM_EVENT = 3'b110,
        TSM_SM_EXT1  = 3'b111
    } tsm_mode_t;

    typedef enum logic [2:0] {
        TSM_SRC_IT0 = 3'b000,
        TSM_SRC_IT1 = 3'b001,
        TSM_SRC_IT2 = 3'b010,
        TSM_SRC_IT3 = 3'b011,
        TSM_SRC_ED  = 3'b100,
        TSM_SRC_CH1 = 3'b101,
        TSM_SRC_CH2 = 3'b110,
        TSM_SRC_ETR = 3'b111
    } tsm_src_t;

    // pin-side trigger inputs, all asynchronous
    typedef struct packed {
        logic [3:0] internal_trigger;
        logic       ch1_filtered_input;
        logic       ch2_filtered_input;
        logic       ext_trigger_filtered;
    } tsm_pin_t;

    // event pulses from the counter core, same clock
    typedef struct packed {
        logic       brk;
        logic       com;
        logic [2:0] cc_hi;
        logic       cc1_out;
        logic       cc1_cap;
        logic       cc1_cmp;
        logic       upd;
    } tsm_evt_t;

    // commands to the counter core
    typedef struct packed {
        logic tick;
        logic down;
        logic reinit;
        logic run;
    } tsm_cnt_t;

endpackage : tsm_pkg

// *** tsm_slave_ctrl.sv ***
`timescale 1ns/1ps
`include "tsm_defines.svh"

module tsm_slave_ctrl
    import tsm_pkg::*;
(
    input  logic        CORE_CLK,
    input  logic        RST,
    input  tsm_pin_t    PINS,
    input  tsm_evt_t    EVT,
    output tsm_cnt_t    CNT,
    output logic        IRQ,
    output logic [6:0]  DMA_REQ,
    input  logic [7:0]  S_AXI_AWADDR,
    input  logic        S_AXI_AWVALID,
    output logic        S_AXI_AWREADY,
    input  logic [31:0] S_AXI_WDATA,
    input  logic [3:0]  S_AXI_WSTRB,
    input  logic        S_AXI_WVALID,
    output logic        S_AXI_WREADY,
    output logic [1:0]  S_AXI_BRESP,
    output logic        S_AXI_BVALID,
    input  logic        S_AXI_BREADY,
    input  logic [7:0]  S_AXI_ARADDR,
    input  logic        S_AXI_ARVALID,
    output logic        S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0]  S_AXI_RRESP,
    output logic        S_AXI_RVALID,
    input  logic        S_AXI_RREADY
);

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    // ****************************************************
    // declarations
    // ****************************************************
    logic [6:0]  sync1_q;
    logic [6:0]  sync2_q;
    tsm_pin_t    pin_s;
    logic        c1p_q;
    logic        c2p_q;
    logic        trp_q;
    logic        e1;
    logic        e2;
    logic        trig_lvl;
    logic        trig_rise;
    logic        trig_fall;
    logic        trig_evt;
    logic        start_evt;
    logic        tick_d;
    logic        down_d;
    logic        reinit_d;
    logic        cc1_evt;
    logic [6:0]  ev_vec;
    logic [7:0]  flag_set;
    logic [7:0]  sr_clr;
    tsm_cnt_t    cnt_q;
    logic        irq_q;
    logic [6:0]  dma_q;
    logic        run_q;
    tsm_mode_t   mode_q;
    tsm_src_t    src_q;
    logic [14:0] ena_q;
    logic [7:0]  sr_q;
    logic        awready_q;
    logic        wready_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        arready_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        wfire;
    logic [3:0]  wsel;
    logic [3:0]  rsel;
    logic [31:0] ctrl_rd;
    logic [31:0] mcfg_rd;
    logic [31:0] ena_rd;
    logic [31:0] sr_rd;
    logic [31:0] ctrl_wm;
    logic [31:0] mcfg_wm;
    logic [31:0] ena_wm;
    logic [31:0] sr_wm;

    // ****************************************************
    // functions
    // ****************************************************
    // one-hot select: ctrl, smcr, dier, sr
    function automatic logic [3:0] reg_sel(input logic [7:0] addr);
        case ({addr[7:2], 2'b00})
            `TSM_OFF_CTRL: reg_sel = 4'h1;
            `TSM_OFF_MODE: reg_sel = 4'h2;
            `TSM_OFF_ENA:  reg_sel = 4'h4;
            `TSM_OFF_SR:   reg_sel = 4'h8;
            default:       reg_sel = 4'h0;
        endcase
    endfunction : reg_sel

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
        wmerge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                wmerge[8*b +: 8] = data[8*b +: 8];
            end
        end
    endfunction : wmerge

    // ****************************************************
    // pin synchronisers
    // ****************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_sync
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= PINS[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign pin_s = tsm_pin_t'(sync2_q);

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            c1p_q <= 1'b0;
            c2p_q <= 1'b0;
            trp_q <= 1'b0;
        end else begin
            c1p_q <= pin_s.ch1_filtered_input;
            c2p_q <= pin_s.ch2_filtered_input;
            trp_q <= trig_lvl;
        end
    end

    assign e1 = pin_s.ch1_filtered_input ^ c1p_q;
    assign e2 = pin_s.ch2_filtered_input ^ c2p_q;

    // ****************************************************
    // trigger selection
    // ****************************************************
    // a mid-mode select change can fake an edge; software avoids it
    always_comb begin
        case (src_q)
            TSM_SRC_IT0: trig_lvl = pin_s.internal_trigger[0];
            TSM_SRC_IT1: trig_lvl = pin_s.internal_trigger[1];
            TSM_SRC_IT2: trig_lvl = pin_s.internal_trigger[2];
            TSM_SRC_IT3: trig_lvl = pin_s.internal_trigger[3];
            TSM_SRC_ED:  trig_lvl = e1;
            TSM_SRC_CH1: trig_lvl = pin_s.ch1_filtered_input;
            TSM_SRC_CH2: trig_lvl = pin_s.ch2_filtered_input;
            TSM_SRC_ETR: trig_lvl = pin_s.ext_trigger_filtered;
            default:     trig_lvl = 1'b0;
        endcase
    end

    assign trig_rise = trig_lvl & ~trp_q;
    assign trig_fall = ~trig_lvl & trp_q;

    // ****************************************************
    // slave mode controller
    // ****************************************************
    // encoder direction: up when ch1 leads ch2, whichever line moves
    always_comb begin
        tick_d    = 1'b0;
        down_d    = cnt_q.down;
        reinit_d  = 1'b0;
        trig_evt  = trig_rise;
        start_evt = 1'b0;
        case (mode_q)
            TSM_SM_DIS: begin
                tick_d   = run_q;
                trig_evt = 1'b0;
            end
            TSM_SM_QD0: begin
                tick_d = run_q & e2;
                if (e2) begin
                    down_d = pin_s.ch2_filtered_input ^ pin_s.ch1_filtered_input;
                end
            end
            TSM_SM_QD1: begin
                tick_d = run_q & e1;
                if (e1) begin
                    down_d = ~(pin_s.ch1_filtered_input ^ pin_s.ch2_filtered_input);
                end
            end
            TSM_SM_QD2: begin
                tick_d = run_q & (e1 | e2);
                if (e1) begin
                    down_d = ~(pin_s.ch1_filtered_input ^ pin_s.ch2_filtered_input);
                end else if (e2) begin
                    down_d = pin_s.ch2_filtered_input ^ pin_s.ch1_filtered_input;
                end
            end
            TSM_SM_RST: begin
                tick_d   = run_q;
                reinit_d = trig_rise;
            end
            TSM_SM_PAUSE: begin
                tick_d   = run_q & trig_lvl;
                trig_evt = trig_rise | trig_fall;
            end
            TSM_SM_EVENT: begin
                tick_d    = run_q;
                start_evt = trig_rise;
            end
            TSM_SM_EXT1: begin
                tick_d = run_q & trig_rise;
            end
            default: begin
                tick_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            cnt_q <= '0;
        end else begin
            cnt_q.tick   <= tick_d;
            cnt_q.down   <= down_d;
            cnt_q.reinit <= reinit_d;
            cnt_q.run    <= run_q;
        end
    end

    sequence s_restart_edge;
        mode_q == TSM_SM_RST && trig_rise;
    endsequence

    sequence s_reinit_pulse;
        cnt_q.reinit ##1 !cnt_q.reinit;
    endsequence

    property p_restart;
        s_restart_edge |=> s_reinit_pulse;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart edge gave no single reinit pulse");

    property p_dis_tick;
        mode_q == TSM_SM_DIS |=> cnt_q.tick == $past(run_q);
    endproperty
    a_dis_tick: assert property (p_dis_tick)
        else $error("disabled mode tick does not follow run bit");

    property p_pause_stop;
        mode_q == TSM_SM_PAUSE && !trig_lvl |=> !cnt_q.tick;
    endproperty
    a_pause_stop: assert property (p_pause_stop)
        else $error("counter ticked while pause trigger low");

    property p_event_start;
        mode_q == TSM_SM_EVENT && trig_rise |=> run_q ##1 cnt_q.run;
    endproperty
    a_event_start: assert property (p_event_start)
        else $error("event mode edge did not start counter");

    property p_quad0;
        mode_q == TSM_SM_QD0 && run_q && e2 |=> cnt_q.tick;
    endproperty
    a_quad0: assert property (p_quad0)
        else $error("channel 2 edge not counted in encoder mode");

    // ****************************************************
    // events, flags, requests
    // ****************************************************
    assign cc1_evt  = EVT.cc1_out ? EVT.cc1_cmp : EVT.cc1_cap;
    assign ev_vec   = {trig_evt, EVT.com, EVT.cc_hi, cc1_evt, EVT.upd};
    assign flag_set = {EVT.brk, ev_vec};
    assign sr_clr   = (wfire && wsel[3]) ? ~sr_wm[7:0] : 8'h00;

    // set wins over a same-cycle software clear
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            sr_q <= `TSM_RST_SR;
        end else begin
            sr_q <= (sr_q & ~sr_clr) | flag_set;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            irq_q <= 1'b0;
            dma_q <= 7'h00;
        end else begin
            irq_q <= |(sr_q & ena_q[7:0]);
            dma_q <= ev_vec & ena_q[14:8];
        end
    end

    property p_trig_flag;
        mode_q == TSM_SM_EXT1 && trig_rise |=> sr_q[6];
    endproperty
    a_trig_flag: assert property (p_trig_flag)
        else $error("trigger flag missed on rising edge");

    property p_pause_fall;
        mode_q == TSM_SM_PAUSE && trig_fall |=> sr_q[6];
    endproperty
    a_pause_fall: assert property (p_pause_fall)
        else $error("trigger flag missed on pause falling edge");

    property p_irq;
        (|(sr_q & ena_q[7:0])) |=> irq_q;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised for enabled flag");

    property p_upd_dma;
        EVT.upd |=> dma_q[0] == $past(ena_q[8]);
    endproperty
    a_upd_dma: assert property (p_upd_dma)
        else $error("update DMA request does not follow enable");

    // ****************************************************
    // software registers
    // ****************************************************
    assign ctrl_rd = {31'h0, run_q};
    assign mcfg_rd = {25'h0, src_q, 1'b0, mode_q};
    assign ena_rd  = {17'h0, ena_q};
    assign sr_rd   = {24'h0, sr_q};
    assign ctrl_wm = wmerge(ctrl_rd, wdata_q, wstrb_q);
    assign mcfg_wm = wmerge(mcfg_rd, wdata_q, wstrb_q);
    assign ena_wm  = wmerge(ena_rd, wdata_q, wstrb_q);
    assign sr_wm   = wmerge(32'hFFFF_FFFF, wdata_q, wstrb_q);
    assign wsel    = reg_sel(awaddr_q);
    assign rsel    = reg_sel(S_AXI_ARADDR);

    // run bit: the event-mode start wins over a same-cycle write
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            run_q <= `TSM_RST_RUN;
        end else begin
            if (wfire && wsel[0]) begin
                run_q <= ctrl_wm[`TSM_RUN_BIT];
            end
            if (start_evt) begin
                run_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            mode_q <= tsm_mode_t'(`TSM_RST_MODE);
            src_q  <= tsm_src_t'(`TSM_RST_MODE);
        end else if (wfire && wsel[1]) begin
            mode_q <= tsm_mode_t'(mcfg_wm[`TSM_MODE_LSB +: 3]);
            src_q  <= tsm_src_t'(mcfg_wm[`TSM_SRC_LSB +: 3]);
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ena_q <= `TSM_RST_ENA;
        end else if (wfire && wsel[2]) begin
            ena_q <= ena_wm[`TSM_ENA_W-1:0];
        end
    end

    // ****************************************************
    // axi4-lite write channel
    // ****************************************************
    assign wfire = !awready_q && !wready_q && !bvalid_q;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            awready_q <= 1'b1;
            awaddr_q  <= 8'h00;
        end else if (S_AXI_AWVALID && awready_q) begin
            awready_q <= 1'b0;
            awaddr_q  <= S_AXI_AWADDR;
        end else if (S_AXI_BREADY && bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wready_q <= 1'b1;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (S_AXI_WVALID && wready_q) begin
            wready_q <= 1'b0;
            wdata_q  <= S_AXI_WDATA;
            wstrb_q  <= S_AXI_WSTRB;
        end else if (S_AXI_BREADY && bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `TSM_RESP_OKAY;
        end else if (wfire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (|wsel) ? `TSM_RESP_OKAY : `TSM_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // ****************************************************
    // axi4-lite read channel
    // ****************************************************
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `TSM_RESP_OKAY;
        end else if (S_AXI_ARVALID && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= ({32{rsel[0]}} & ctrl_rd) | ({32{rsel[1]}} & mcfg_rd)
                       | ({32{rsel[2]}} & ena_rd) | ({32{rsel[3]}} & sr_rd);
            rresp_q   <= (|rsel) ? `TSM_RESP_OKAY : `TSM_RESP_SLVERR;
        end else if (S_AXI_RREADY && rvalid_q) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    property p_resv;
        S_AXI_ARVALID && arready_q && rsel[2] |=> rdata_q[31:15] == 17'h0;
    endproperty
    a_resv: assert property (p_resv)
        else $error("reserved enable bits read nonzero");

    // ****************************************************
    // outputs
    // ****************************************************
    assign CNT           = cnt_q;
    assign IRQ           = irq_q;
    assign DMA_REQ       = dma_q;
    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY  = wready_q;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;

endmodule : tsm_slave_ctrl

// *** tsm_core_model.sv ***
`timescale 1ns/1ps
// ****************************************
// counter core and dma controller stand-in
// ****************************************
module tsm_core_model
    import tsm_pkg::*;
(
    input  logic        CORE_CLK,
    input  logic        RST,
    input  tsm_cnt_t    CNT,
    input  logic [6:0]  DMA_REQ,
    output logic [15:0] TICKS,
    output logic [15:0] POS,
    output logic [15:0] REINITS,
    output logic [15:0] DMAS
);
    // position wraps freely; only differences matter to the bench
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            TICKS   <= 16'h0;
            POS     <= 16'h0;
            REINITS <= 16'h0;
            DMAS    <= 16'h0;
        end else begin
            if (CNT.tick) begin
                TICKS <= TICKS + 16'h1;
                POS   <= CNT.down ? POS - 16'h1 : POS + 16'h1;
            end
            if (CNT.reinit)
                REINITS <= REINITS + 16'h1;
            DMAS <= DMAS + 16'($countones(DMA_REQ));
        end
    end
endmodule : tsm_core_model

// *** tsm_slave_ctrl_tb.sv ***
`timescale 1ns/1ps
`include "tsm_defines.svh"
// ****************************************
// bench
// ****************************************
module tsm_slave_ctrl_tb
    import tsm_pkg::*;
;
    logic        core_clk, rst, irq;
    tsm_pin_t    pins;
    tsm_evt_t    evt;
    tsm_cnt_t    cnt;
    logic [6:0]  dma_req;
    logic [7:0]  awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [15:0] ticks, pos, reinits, dmas, n0;
    int          errors, samples_checked, cycles;

    tsm_slave_ctrl DUT (.CORE_CLK(core_clk), .RST(rst), .PINS(pins), .EVT(evt), .CNT(cnt),
        .IRQ(irq), .DMA_REQ(dma_req), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1));
    tsm_core_model FAR (.CORE_CLK(core_clk), .RST(rst), .CNT(cnt), .DMA_REQ(dma_req),
        .TICKS(ticks), .POS(pos), .REINITS(reinits), .DMAS(dmas));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic conclude;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    // runaway guard, well above the expected run of just over a thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %0h", $time, m, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge core_clk);
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (bvalid !== 1'b1);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                        input string m);
        logic ar;
        ar = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (ar && arready) begin
                ar = 1'b0;
                arvalid <= 1'b0;
            end
        end while (rvalid !== 1'b1);
        chk(rdata, e, m);
        chk({30'h0, rresp}, {30'h0, er}, m);
    endtask : rchk

    task automatic drive_src(input int s, input logic v);
        case (s)
            0, 1, 2, 3: pins.internal_trigger[s] <= v;
            4, 5: pins.ch1_filtered_input <= v;
            6: pins.ch2_filtered_input <= v;
            default: pins.ext_trigger_filtered <= v;
        endcase
    endtask : drive_src

    task automatic pulse(input int s, input int n);
        drive_src(s, 1'b1);
        cyc(n);
        drive_src(s, 1'b0);
        cyc(n);
    endtask : pulse

    // mode dropped to disabled before the source moves
    task automatic set_mode(input logic [2:0] s, input logic [2:0] m);
        wr(`TSM_OFF_MODE, 32'h0);
        wr(`TSM_OFF_MODE, {25'h0, s, 4'h0});
        wr(`TSM_OFF_MODE, {25'h0, s, 1'b0, m});
        cyc(2);
    endtask : set_mode

    task automatic t_regs;
        rchk(`TSM_OFF_ENA, 32'h0, `TSM_RESP_OKAY, "enable reset");
        wr(`TSM_OFF_ENA, 32'hFFFF_FFFF);
        rchk(`TSM_OFF_ENA, 32'h0000_7FFF, `TSM_RESP_OKAY, "enable bits");
        rchk(8'h40, 32'h0, `TSM_RESP_SLVERR, "unmapped");
        wr(`TSM_OFF_ENA, 32'h0);
    endtask : t_regs

    // every pin pulsed in turn; only the selected one may clock the counter
    task automatic t_src;
        wr(`TSM_OFF_CTRL, 32'h1);
        for (int s = 0; s < 8; s++) begin
            set_mode(3'(s), TSM_SM_EXT1);
            rchk(`TSM_OFF_MODE, {25'h0, 3'(s), 4'h7}, `TSM_RESP_OKAY, "mode readback");
            n0 = ticks;
            for (int j = 0; j < 8; j++)
                pulse(j, 5);
            chk({16'h0, ticks - n0}, (s == 4) ? 4 : (s == 5) ? 2 : 1, "source");
        end
    endtask : t_src

    // one quadrature cycle forward: ch1 up, ch2 up, ch1 down, ch2 down
    task automatic t_quad;
        for (int m = 1; m < 4; m++) begin
            set_mode(3'h0, 3'(m));
            n0 = pos;
            drive_src(4, 1'b1);
            cyc(6);
            drive_src(6, 1'b1);
            cyc(6);
            drive_src(4, 1'b0);
            cyc(6);
            drive_src(6, 1'b0);
            cyc(6);
            chk({16'h0, pos - n0}, (m == 3) ? 4 : 2, "encoder steps");
        end
    endtask : t_quad

    task automatic t_trig;
        set_mode(3'h7, TSM_SM_PAUSE);
        n0 = ticks;
        pulse(7, 10);
        chk({16'h0, ticks - n0}, 10, "pause ticks");
        drive_src(7, 1'b1);
        cyc(5);
        wr(`TSM_OFF_SR, 32'h0);
        drive_src(7, 1'b0);
        cyc(5);
        rchk(`TSM_OFF_SR, 32'h40, `TSM_RESP_OKAY, "pause falling flag");
        set_mode(3'h7, TSM_SM_RST);
        n0 = reinits;
        pulse(7, 5);
        pulse(7, 5);
        chk({16'h0, reinits - n0}, 2, "restart");
        set_mode(3'h7, TSM_SM_DIS);
        n0 = ticks;
        cyc(10);
        chk({16'h0, ticks - n0}, 10, "free run");
        set_mode(3'h7, TSM_SM_EVENT);
        wr(`TSM_OFF_CTRL, 32'h0);
        cyc(3);
        chk({31'h0, cnt.run}, 0, "event idle");
        pulse(7, 5);
        cyc(5);
        chk({31'h0, cnt.run}, 1, "event start");
        rchk(`TSM_OFF_CTRL, 32'h1, `TSM_RESP_OKAY, "event run bit");
    endtask : t_trig

    task automatic t_irq;
        set_mode(3'h7, TSM_SM_DIS);
        wr(`TSM_OFF_ENA, 32'h0000_0101);
        wr(`TSM_OFF_SR, 32'h0);
        n0 = dmas;
        evt.upd <= 1'b1;
        cyc(1);
        evt.upd <= 1'b0;
        cyc(4);
        chk({16'h0, dmas - n0}, 1, "update dma");
        chk({31'h0, irq}, 1, "update irq");
        wr(`TSM_OFF_SR, 32'h0);
        cyc(3);
        chk({31'h0, irq}, 0, "irq cleared");
        wr(`TSM_OFF_ENA, 32'h0);
        evt.upd <= 1'b1;
        cyc(1);
        evt.upd <= 1'b0;
        cyc(4);
        chk({16'h0, dmas - n0}, 1, "dma masked");
        chk({31'h0, irq}, 0, "irq masked");
        // channel 1 as output: capture must not flag, compare must
        wr(`TSM_OFF_SR, 32'h0);
        evt.cc1_out <= 1'b1;
        evt.cc1_cap <= 1'b1;
        cyc(1);
        evt.cc1_cap <= 1'b0;
        cyc(3);
        rchk(`TSM_OFF_SR, 32'h0, `TSM_RESP_OKAY, "cc1 capture as output");
        evt.cc1_cmp <= 1'b1;
        cyc(1);
        evt.cc1_cmp <= 1'b0;
        cyc(3);
        rchk(`TSM_OFF_SR, 32'h2, `TSM_RESP_OKAY, "cc1 compare as output");
    endtask : t_irq

    initial begin
        rst = 1'b1;
        pins = '0;
        evt = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_src();
        t_quad();
        t_trig();
        t_irq();
        conclude();
    end
endmodule : tsm_slave_ctrl_tb
